// ---- hw/uart_pkg.sv ----
// Purpose: Shared constants for the asynchronous serial port (modes 1, 2, 3)
// Assumes: Classic Wishbone register access, 32-bit data, one clock
// Notes: All offsets and fields, the control and reload reset values and the sample points live here
package uart_pkg;
  // Register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0; // Control and status
  localparam logic [3:0] DATA_OFS = 4'h4; // Serial buffer
  localparam logic [3:0] BAUD_OFS = 4'h8; // Timer 1 overflow reload
  // Control register fields
  localparam int MODE_LSB = 0; // Two-bit mode field, 0 unused
  localparam int RXEN_BIT = 2; // Receive enable
  localparam int MPF_BIT = 3; // multiproc_filter_enable
  localparam int TX9_BIT = 4; // tx_ninth_bit
  localparam int RX9_BIT = 5; // rx_ninth_bit
  localparam int TXDONE_BIT = 6; // tx_done_flag
  localparam int RXDONE_BIT = 7; // rx_done_flag
  localparam int M2DIV_BIT = 8; // Mode 2: 0 = clk/32, 1 = clk/16
  localparam int TXBUSY_BIT = 9; // Read only: frame in progress
  // Mode encodings
  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;
  localparam logic [1:0] MODE_3 = 2'h3;
  // Reset values
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam logic [15:0] BAUD_RST = 16'h0000;
  // Oversampling
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] SAMPLE_A = 4'h6; // 7th state (counted from 0)
  localparam logic [3:0] SAMPLE_B = 4'h7; // 8th state
  localparam logic [3:0] SAMPLE_C = 4'h8; // 9th state
  localparam logic [8:0] RX_PRESET = 9'h1FF;
endpackage

// ---- hw/uart_tick_gen.sv ----
// Purpose: Sixteen-times bit rate tick for the serial port
// Assumes: Mode 2 ticks from the core clock, modes 1 and 3 from timer overflow
// Notes: Timer 1 is modelled as a reload counter; mode 2 clk/32 halves clk/16
`timescale 1ns/1ps
`default_nettype none
module uart_tick_gen (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Configuration
  input wire logic [1:0] mode_i,
  input wire logic m2_fast_i,
  input wire logic [15:0] reload_i,
  // Sixteen-times tick
  output logic tick16_o
);
  logic [15:0] tmr_q, tmr_d; // Overflow counter, counts up to wrap
  logic half_q, half_d; // Divide-by-two for mode 2 slow rate
  logic tick_d;

  // Next values: mode 2 fixed rate, others on timer overflow
  always_comb begin
    tmr_d = tmr_q;
    half_d = half_q;
    tick_d = 1'b0;
    if (mode_i == uart_pkg::MODE_2) begin
      // Core clock already is the sixteen-times tick of the faster rate
      half_d = ~half_q;
      tick_d = m2_fast_i | half_q;
      // Timer waits at the reload value, so modes 1 and 3 open with a full period
      tmr_d = reload_i;
    end else if (tmr_q == 16'hFFFF) begin
      tmr_d = reload_i;
      tick_d = 1'b1;
    end else begin
      tmr_d = tmr_q + 16'h0001;
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmr_q <= uart_pkg::BAUD_RST;
      half_q <= 1'b0;
      tick16_o <= 1'b0;
    end else begin
      tmr_q <= tmr_d;
      half_q <= half_d;
      tick16_o <= tick_d;
    end
  end
endmodule
`default_nettype wire

// ---- hw/uart_vote.sv ----
// Purpose: Two-of-three majority bit detector
// Assumes: Samples taken on the tick at states 7, 8 and 9 of the bit
// Notes: Outputs the vote combinationally at the third sample, from the live line
`timescale 1ns/1ps
`default_nettype none
module uart_vote (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Sampling
  input wire logic tick_i,
  input wire logic [3:0] phase_i,
  input wire logic line_i,
  // Result
  output logic bit_o
);
  logic [1:0] smp_q, smp_d; // First two samples

  // Capture first two samples
  always_comb begin
    smp_d = smp_q;
    if (tick_i && phase_i == uart_pkg::SAMPLE_A) smp_d[0] = line_i;
    if (tick_i && phase_i == uart_pkg::SAMPLE_B) smp_d[1] = line_i;
  end

  // Majority of the two held samples and the live third one
  always_comb begin
    bit_o = (smp_q[0] & smp_q[1]) | (smp_q[0] & line_i) | (smp_q[1] & line_i);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) smp_q <= 2'h3;
    else smp_q <= smp_d;
  end
endmodule
`default_nettype wire

// ---- hw/uart_serial_port.sv ----
// Purpose: Asynchronous serial port, modes 1, 2 and 3, with Wishbone registers
// Assumes: serial_in_line synchronous to clk_i; software clears done flags
// Notes: Bit timing comes from a divide-by-16 of a sixteen-times tick
// Operation
// - Mode 1 accept: stop bit, byte, done flag
// - Failed mode 1 checks discard the frame
// - Mode 1 returns to edge hunt after final
// - Frame: start, 8 data LSB first, ninth, stop
// - Ninth bit sent from tx, stored into rx
// - Mode 2 rate clock over 16 or 32
// - Mode 3 rate from timer 1 overflow
// - Buffer write loads ninth bit, requests send
// - Transmit starts after next counter rollover
// - Start bit, then data, then first shift
// - First shift inserts stop (zero in mode 1), then zeros
// - Last shift ends frame, sets transmit flag
// - Sample 16x, falling edge resets counter, presets
// - Majority of samples at states 7-9
// - Non-zero start bit resets receiver
// - Nine-bit receive shift, final shift attempts load
// - Accept only if flag clear and filter passes
// - Modes 2, 3 hunt one bit later
// - Mode 1 frame ten bits, timer rate
// - Mode 1 loads one into ninth position
`timescale 1ns/1ps
`default_nettype none
module uart_serial_port (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial link
  input wire logic serial_in_line,
  output logic serial_out_line
);
  // Transmit states
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_WAIT = 3'b010,
    TX_RUN = 3'b100
  } tx_state_e;
  // Receive states
  typedef enum logic [2:0] {
    RX_HUNT = 3'b001,
    RX_BITS = 3'b010,
    RX_TAIL = 3'b100
  } rx_state_e;

  // Control register fields
  logic [1:0] mode_q, mode_d;
  logic rx_en_q, rx_en_d;
  logic multiproc_filter_enable_q, multiproc_filter_enable_d;
  logic tx_ninth_bit_q, tx_ninth_bit_d;
  logic rx_ninth_bit_q, rx_ninth_bit_d;
  logic tx_done_flag_q, tx_done_flag_d;
  logic rx_done_flag_q, rx_done_flag_d;
  logic m2_fast_q, m2_fast_d;
  logic [15:0] reload_q, reload_d; // Timer 1 reload value
  logic [7:0] serial_buffer_q, serial_buffer_d; // Received byte
  // Bus answer
  logic ack_d;
  logic [31:0] rdat_d;
  // Bit timing
  logic tick16;
  logic [3:0] tx_div_q, tx_div_d; // Free divide-by-16 for transmit
  logic [3:0] rx_div_q, rx_div_d; // Receive divide-by-16, reset on edge
  // Transmit path
  tx_state_e tx_st_q, tx_st_d;
  logic [8:0] tx_shift_q, tx_shift_d;
  logic tx_first_q, tx_first_d; // Shift not yet done
  logic tx_data_q, tx_data_d; // Data phase: shift output drives line
  logic tx_req_q, tx_req_d;
  logic tx_frame_active_q, tx_frame_active_d;
  logic line_d;
  // Receive path
  rx_state_e rx_st_q, rx_st_d;
  logic [8:0] rx_shift_q, rx_shift_d;
  logic line_prev_q, line_prev_d; // Previous sixteen-times sample
  logic rx_bit;
  logic rx_first_q, rx_first_d; // Still in the start bit time
  logic rx_m1_q, rx_m1_d; // Frame received in mode 1

  // Handy decodes
  logic bus_wr, wr_ctrl, wr_data, wr_baud, tx_roll, rx_mid;
  logic mode_ok;

  // Byte-lane merge of a written word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // Bits enter the receive register from the right, LSB first, so the byte lands mirrored
  function automatic logic [7:0] mirror8(input logic [7:0] v);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7 - i];
    end
    return r;
  endfunction

  uart_tick_gen u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mode_i(mode_q),
    .m2_fast_i(m2_fast_q),
    .reload_i(reload_q),
    .tick16_o(tick16)
  );

  uart_vote u_vote (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick16),
    .phase_i(rx_div_q),
    .line_i(serial_in_line),
    .bit_o(rx_bit)
  );

  // Decodes shared by both paths
  always_comb begin
    bus_wr = cyc_i & stb_i & we_i & ~ack_o;
    wr_ctrl = bus_wr & (adr_i == uart_pkg::CTRL_OFS);
    wr_data = bus_wr & (adr_i == uart_pkg::DATA_OFS) & sel_i[0];
    wr_baud = bus_wr & (adr_i == uart_pkg::BAUD_OFS);
    tx_roll = tick16 & (tx_div_q == 4'hF);
    rx_mid = tick16 & (rx_div_q == uart_pkg::SAMPLE_C);
    mode_ok = mode_q != 2'h0;
  end

  // Register file next values, Wishbone answer one cycle after request
  always_comb begin
    logic [31:0] c;
    logic [31:0] b; // Timer reload with the written lanes applied
    c = merge({23'h0, m2_fast_q, rx_done_flag_q, tx_done_flag_q, rx_ninth_bit_q,
               tx_ninth_bit_q, multiproc_filter_enable_q, rx_en_q, mode_q}, dat_i, sel_i);
    b = merge({16'h0, reload_q}, dat_i, sel_i);
    mode_d = mode_q;
    rx_en_d = rx_en_q;
    multiproc_filter_enable_d = multiproc_filter_enable_q;
    tx_ninth_bit_d = tx_ninth_bit_q;
    m2_fast_d = m2_fast_q;
    reload_d = reload_q;
    ack_d = cyc_i & stb_i & ~ack_o; // Unmapped offsets still answer, reading zero
    rdat_d = 32'h0000_0000;
    if (wr_ctrl) begin
      mode_d = c[uart_pkg::MODE_LSB +: 2];
      rx_en_d = c[uart_pkg::RXEN_BIT];
      multiproc_filter_enable_d = c[uart_pkg::MPF_BIT];
      tx_ninth_bit_d = c[uart_pkg::TX9_BIT];
      m2_fast_d = c[uart_pkg::M2DIV_BIT];
    end
    if (wr_baud) reload_d = b[15:0];
    if (cyc_i & stb_i & ~we_i & ~ack_o) begin
      unique case (adr_i)
        uart_pkg::CTRL_OFS: rdat_d = {22'h0, tx_frame_active_q, m2_fast_q, rx_done_flag_q,
                                      tx_done_flag_q, rx_ninth_bit_q, tx_ninth_bit_q,
                                      multiproc_filter_enable_q, rx_en_q, mode_q};
        uart_pkg::DATA_OFS: rdat_d = {24'h0, serial_buffer_q};
        uart_pkg::BAUD_OFS: rdat_d = {16'h0, reload_q};
        default: rdat_d = 32'h0000_0000;
      endcase
    end
  end

  // Transmit sequencer
  always_comb begin
    tx_div_d = tick16 ? tx_div_q + 4'h1 : tx_div_q;
    tx_st_d = tx_st_q;
    tx_shift_d = tx_shift_q;
    tx_first_d = tx_first_q;
    tx_data_d = tx_data_q;
    tx_req_d = tx_req_q;
    tx_frame_active_d = tx_frame_active_q;
    tx_done_flag_d = tx_done_flag_q;
    if (wr_ctrl && !dat_i[uart_pkg::TXDONE_BIT] && sel_i[0]) tx_done_flag_d = 1'b0;
    if (wr_data && mode_ok) begin
      // Mode 1 puts a one in the ninth place, modes 2 and 3 the ninth bit
      tx_shift_d = {(mode_q == uart_pkg::MODE_1) ? 1'b1 : tx_ninth_bit_q, dat_i[7:0]};
      tx_req_d = 1'b1;
      tx_st_d = TX_WAIT;
      tx_frame_active_d = 1'b0;
      tx_data_d = 1'b0;
    end else begin
      unique case (tx_st_q)
        TX_IDLE: ;
        TX_WAIT: if (tx_roll && tx_req_q) begin
          // Start aligned to the divider, not to the write
          tx_st_d = TX_RUN;
          tx_frame_active_d = 1'b1;
          tx_req_d = 1'b0;
          tx_first_d = 1'b1;
        end
        TX_RUN: if (tx_roll) begin
          if (!tx_data_q) begin
            tx_data_d = 1'b1;
          end else if (mode_q == uart_pkg::MODE_1 ? tx_shift_q[8:1] == 8'h01 && !tx_first_q
                       : tx_shift_q[8:1] == 8'h01 && !tx_first_q) begin
            // Ninth or last data bit out, stop next, zeros beyond
            tx_shift_d = {1'b0, tx_shift_q[8:1]};
            tx_frame_active_d = 1'b0;
            tx_data_d = 1'b0;
            tx_done_flag_d = 1'b1;
            tx_st_d = TX_IDLE;
          end else begin
            // First shift brings in the stop bit in modes 2 and 3
            tx_shift_d = {tx_first_q && mode_q != uart_pkg::MODE_1, tx_shift_q[8:1]};
            tx_first_d = 1'b0;
          end
        end
        default: tx_st_d = TX_IDLE;
      endcase
    end
    // Line: idle high, start low, then shift output, then stop
    if (!tx_frame_active_d) line_d = 1'b1;
    else if (!tx_data_d) line_d = 1'b0;
    else line_d = tx_shift_d[0];
  end

  // Receiver
  always_comb begin
    logic accept;
    accept = 1'b0;
    rx_div_d = tick16 ? rx_div_q + 4'h1 : rx_div_q;
    rx_st_d = rx_st_q;
    rx_shift_d = rx_shift_q;
    rx_first_d = rx_first_q;
    rx_m1_d = rx_m1_q;
    line_prev_d = tick16 ? serial_in_line : line_prev_q;
    serial_buffer_d = serial_buffer_q;
    rx_ninth_bit_d = rx_ninth_bit_q;
    rx_done_flag_d = rx_done_flag_q;
    if (wr_ctrl && !dat_i[uart_pkg::RXDONE_BIT] && sel_i[0]) rx_done_flag_d = 1'b0;
    unique case (rx_st_q)
      RX_HUNT: if (tick16 && line_prev_q && !serial_in_line && rx_en_q && mode_ok) begin
        rx_div_d = 4'h0;
        rx_shift_d = uart_pkg::RX_PRESET;
        rx_first_d = 1'b1;
        rx_m1_d = mode_q == uart_pkg::MODE_1;
        rx_st_d = RX_BITS;
      end
      RX_BITS: if (rx_mid) begin
        if (rx_first_q && rx_bit) begin
          rx_st_d = RX_HUNT;
        end else if (!rx_shift_q[8]) begin
          // Start bit at the left end: final shift and load attempt
          rx_shift_d = {rx_shift_q[7:0], rx_bit};
          if (rx_m1_q) begin
            accept = !rx_done_flag_q && (!multiproc_filter_enable_q || rx_bit);
            if (accept) begin
              serial_buffer_d = mirror8(rx_shift_q[7:0]);
              rx_ninth_bit_d = rx_bit;
            end
            rx_st_d = RX_HUNT;
          end else begin
            accept = !rx_done_flag_q && (!multiproc_filter_enable_q || rx_bit);
            if (accept) begin
              serial_buffer_d = mirror8(rx_shift_q[7:0]);
              rx_ninth_bit_d = rx_bit;
            end
            rx_st_d = RX_TAIL;
          end
        end else begin
          rx_shift_d = {rx_shift_q[7:0], rx_bit};
          rx_first_d = 1'b0;
        end
      end
      RX_TAIL: if (rx_mid) rx_st_d = RX_HUNT;
      default: rx_st_d = RX_HUNT;
    endcase
    if (accept) rx_done_flag_d = 1'b1;
  end

  // All state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= uart_pkg::CTRL_RST[1:0];
      rx_en_q <= 1'b0;
      multiproc_filter_enable_q <= 1'b0;
      tx_ninth_bit_q <= 1'b0;
      rx_ninth_bit_q <= 1'b0;
      tx_done_flag_q <= 1'b0;
      rx_done_flag_q <= 1'b0;
      m2_fast_q <= 1'b0;
      reload_q <= uart_pkg::BAUD_RST;
      serial_buffer_q <= 8'h00;
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      tx_div_q <= 4'h0;
      rx_div_q <= 4'h0;
      tx_st_q <= TX_IDLE;
      tx_shift_q <= 9'h1FF;
      tx_first_q <= 1'b0;
      tx_data_q <= 1'b0;
      tx_req_q <= 1'b0;
      tx_frame_active_q <= 1'b0;
      serial_out_line <= 1'b1;
      rx_st_q <= RX_HUNT;
      rx_shift_q <= uart_pkg::RX_PRESET;
      line_prev_q <= 1'b1;
      rx_first_q <= 1'b0;
      rx_m1_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      rx_en_q <= rx_en_d;
      multiproc_filter_enable_q <= multiproc_filter_enable_d;
      tx_ninth_bit_q <= tx_ninth_bit_d;
      rx_ninth_bit_q <= rx_ninth_bit_d;
      tx_done_flag_q <= tx_done_flag_d;
      rx_done_flag_q <= rx_done_flag_d;
      m2_fast_q <= m2_fast_d;
      reload_q <= reload_d;
      serial_buffer_q <= serial_buffer_d;
      ack_o <= ack_d;
      dat_o <= rdat_d;
      tx_div_q <= tx_div_d;
      rx_div_q <= rx_div_d;
      tx_st_q <= tx_st_d;
      tx_shift_q <= tx_shift_d;
      tx_first_q <= tx_first_d;
      tx_data_q <= tx_data_d;
      tx_req_q <= tx_req_d;
      tx_frame_active_q <= tx_frame_active_d;
      serial_out_line <= line_d;
      rx_st_q <= rx_st_d;
      rx_shift_q <= rx_shift_d;
      line_prev_q <= line_prev_d;
      rx_first_q <= rx_first_d;
      rx_m1_q <= rx_m1_d;
    end
  end
endmodule
`default_nettype wire

// ---- tb/uart_serial_port_properties.sv ----
// Purpose: Port-level checks for the serial port
// Assumes: Sees only top-level ports; a bit lasts at least 16 clocks
// Notes: Bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module uart_sp_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus side
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Serial side
  input wire logic serial_out_line
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Set once a data write has been answered
  logic wr_q;
  logic wr_d;
  always_comb wr_d = wr_q | (ack_o && we_i && adr_i == uart_pkg::DATA_OFS);
  always_ff @(posedge clk_i) wr_q <= rst_i ? 1'b0 : wr_d;
  a_ack_next_cycle: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  a_ack_one_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
  a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack unasked");
  a_unmapped_zero: assert property (ack_o && !we_i && adr_i == 4'hC |-> dat_o == 32'h0) else $error("bad read");
  a_idle_after_reset: assert property (disable iff (1'b0) rst_i |=> serial_out_line) else $error("not idle");
  a_start_bit_held: assert property ($fell(serial_out_line) |-> !serial_out_line [*8]) else $error("start short");
  a_bit_min_width: assert property ($changed(serial_out_line) |=> $stable(serial_out_line) [*7]) else $error("bit short");
  a_tx_needs_write: assert property ($fell(serial_out_line) |-> wr_q) else $error("unasked frame");
  // Main scenarios reached
  cover property (ack_o && we_i);
  cover property ($fell(serial_out_line));
  cover property (ack_o && !we_i && adr_i == 4'hC);
endmodule
bind uart_serial_port uart_sp_props u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .serial_out_line(serial_out_line));
`default_nettype wire

// ---- tb/serial_peer_model.sv ----
// Purpose: Remote asynchronous serial peer
// Assumes: One bit lasts per clocks in both directions
// Notes: Line idles high; frames sent and sampled on request
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model (
  // Clock
  input wire logic clk_i,
  // Line from the port
  input wire logic tx_line_i,
  // Line into the port
  output logic rx_line_o
);
  // Mark level between frames
  initial rx_line_o = 1'b1;
  // Start, data LSB first, ninth or stop; sp flips one clock mid-bit as noise
  task automatic send(input logic [7:0] d, input logic b9, input bit nine, input int per, input int sp);
    logic [10:0] f;
    f = {1'b1, b9, d, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      for (int c = 0; c < per; c++) begin
        @(posedge clk_i);
        rx_line_o <= f[i] ^ (i == sp && c == per / 2 - 1);
      end
    end
    @(posedge clk_i);
    rx_line_o <= 1'b1;
  endtask
  // Short low pulse, too short for a start bit
  task automatic glitch(input int n);
    @(posedge clk_i);
    rx_line_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    rx_line_o <= 1'b1;
    repeat (40) @(posedge clk_i);
  endtask
  // Waits for a start edge, bounded, then samples each bit centre
  task automatic recv(input int per, input bit nine, output logic [10:0] f, output int w);
    w = 0;
    f = '1;
    while (tx_line_i !== 1'b0 && w < 4000) begin
      @(posedge clk_i);
      w++;
    end
    repeat (per / 2) @(posedge clk_i);
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      f[i] = tx_line_i;
      if (i < (nine ? 10 : 9)) repeat (per) @(posedge clk_i);
    end
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_async_serial_port_modes_1_2_3.sv ----
// Purpose: Self-checking bench for the serial port
// Assumes: Mode 2 fast and reload FFFF give 16 clocks a bit
// Notes: Control values: bit 2 rx enable, 3 filter, 4 ninth, 8 fast
`timescale 1ns/1ps
`default_nettype none
module tb_async_serial_port_modes_1_2_3;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, rx_line, tx_line;
  logic [3:0] adr_i, sel_i;
  logic [31:0] dat_i, dat_o, rd;
  int bad_count, cmp_count;
  localparam logic [9:0] C2 = 10'h106; // Mode 2 fast, rx on
  localparam logic [9:0] C1 = 10'h005; // Mode 1, rx on
  localparam logic [9:0] MPF = 10'h008; // Filter on
  uart_serial_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .serial_in_line(rx_line),
    .serial_out_line(tx_line));
  serial_peer_model u_peer (.clk_i(clk_i), .tx_line_i(tx_line), .rx_line_o(rx_line));
  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Counts, verdict, end of run
  task automatic wrap_up;
    $display("bad_count=%0d cmp_count=%0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Classic cycle; held until ack, then released for at least one cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= 4'hF;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      wrap_up();
    end
  endtask
  // Reset values, unmapped read, idle line
  task automatic t_reset;
    chk(32'(tx_line), 32'h1);
    wb(1'b0, uart_pkg::CTRL_OFS, 32'h0);
    chk(rd, 32'(uart_pkg::CTRL_RST));
    wb(1'b0, uart_pkg::BAUD_OFS, 32'h0);
    chk(rd, 32'(uart_pkg::BAUD_RST));
    wb(1'b0, 4'hC, 32'h0);
    chk(rd, 32'h0);
  endtask
  // Sends one byte; checks the frame, start delay and done flag
  task automatic t_tx(input logic [9:0] c, input logic [7:0] d, input int per, input bit nine);
    logic [10:0] f;
    int w;
    wb(1'b1, uart_pkg::CTRL_OFS, 32'(c));
    wb(1'b1, uart_pkg::DATA_OFS, 32'(d));
    u_peer.recv(per, nine, f, w);
    chk(32'(f), 32'({1'b1, nine ? c[uart_pkg::TX9_BIT] : 1'b1, d, 1'b0}));
    chk(32'(w <= per + 4), 32'h1);
    wb(1'b0, uart_pkg::CTRL_OFS, 32'h0);
    chk(32'(rd[uart_pkg::TXDONE_BIT]), 32'h1);
  endtask
  // Peer sends one frame; ex holds done flag, ninth bit and byte expected
  task automatic t_rx(input bit cfg, input logic [9:0] c, input logic [8:0] v, input bit nine, input int sp,
      input logic [9:0] ex);
    if (cfg) wb(1'b1, uart_pkg::CTRL_OFS, 32'(c));
    u_peer.send(v[7:0], v[8], nine, 16, sp);
    repeat (16) @(posedge clk_i);
    wb(1'b0, uart_pkg::CTRL_OFS, 32'h0);
    chk(32'({rd[uart_pkg::RXDONE_BIT], rd[uart_pkg::RX9_BIT]}), 32'(ex[9:8]));
    wb(1'b0, uart_pkg::DATA_OFS, 32'h0);
    chk(rd & 32'hFF, 32'(ex[7:0]));
  endtask
  initial begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 4'h0;
    sel_i = 4'hF;
    dat_i = 32'h0;
    bad_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_tx(10'h112, 8'hA5, 16, 1'b1);
    t_tx(10'h102, 8'h3C, 16, 1'b1);
    t_tx(10'h012, 8'h5A, 32, 1'b1);
    wb(1'b1, uart_pkg::BAUD_OFS, 32'h0000FFFF);
    t_tx(10'h013, 8'hC3, 16, 1'b1);
    t_tx(10'h001, 8'h81, 16, 1'b0);
    t_rx(1'b1, C2, 9'h196, 1'b1, -1, 10'h396);
    t_rx(1'b0, C2, 9'h011, 1'b1, -1, 10'h396);
    t_rx(1'b1, C2 | MPF, 9'h022, 1'b1, -1, 10'h196);
    t_rx(1'b0, C2 | MPF, 9'h144, 1'b1, 3, 10'h344);
    wb(1'b1, uart_pkg::CTRL_OFS, 32'(C2));
    u_peer.glitch(3);
    t_rx(1'b0, C2, 9'h077, 1'b1, -1, 10'h277);
    t_rx(1'b1, C1, 9'h1E7, 1'b0, -1, 10'h3E7);
    t_rx(1'b1, C1 | MPF, 9'h018, 1'b0, -1, 10'h1E7);
    t_rx(1'b0, C1 | MPF, 9'h15E, 1'b0, -1, 10'h35E);
    wrap_up();
  end
endmodule
`default_nettype wire
